// ===== hdl/serial_tx_control_ext_status.sv
`timescale 1ns/100ps
module serial_tx_control_ext_status (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // AXI4-Lite slave
  input  wire logic [sio_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [sio_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // Serial line and modem pins
  input  wire logic                       txClkPin,
  input  wire logic                       ctsPin_n,
  input  wire logic                       dcdPin_n,
  input  wire logic                       syncPin_n,
  output logic                            txData,
  output logic                            rtsPin_n,
  output logic                            dtrPin_n,
  // Receiver events, same clock
  input  wire logic                       rxNullFrameErr,
  input  wire logic                       rxAbortSeen,
  input  wire logic                       rxBreakEnd,
  input  wire logic                       rxSyncAchieved,
  input  wire logic                       rxEnable,
  input  wire logic                       rxCharAvail,
  // External/status request
  output logic                            extStatusReq
);

  logic rstMeta_ff;
  logic rstSync_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_n  <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_n  <= rstMeta_ff;
    end
  end

  // Pin synchronisers
  logic [3:0] pinSync;
  logic       txClkS;
  logic       ctsS_n;
  logic       dcdS_n;
  logic       syncS_n;

  sync_two_ff #(.WIDTH(4)) pinSyncInst (
    .clk     (ref_clk),
    .rst_n   (rstSync_n),
    .asyncIn ({txClkPin, ctsPin_n, dcdPin_n, syncPin_n}),
    .syncOut (pinSync)
  );

  assign {txClkS, ctsS_n, dcdS_n, syncS_n} = pinSync;

  logic txClkPrev_ff;
  wire  bitTick = txClkPrev_ff & ~txClkS;

  // Registers
  sio_pkg::txctl_type   txctl_ff;
  sio_pkg::ctrl_type    ctrl_ff;
  sio_pkg::txstate_type txState_ff;
  sio_pkg::txstate_type nxt_txState;
  logic [7:0]           bufData_ff;
  logic                 bufFull_ff;
  logic [15:0]          shift_ff;
  logic [15:0]          nxt_shift;
  logic [4:0]           bitsLeft_ff;
  logic [4:0]           nxt_bitsLeft;
  logic [15:0]          crc_ff;
  logic [15:0]          nxt_crc;
  logic                 eom_ff;
  logic                 nxt_eom;
  logic                 rtsOut_ff;
  logic [3:0]           snap_ff;
  logic                 locked_ff;
  logic                 pending_ff;
  logic                 brkLive_ff;
  logic                 huntLive_ff;

  // AXI write side
  logic                       awHeld_ff;
  logic [sio_pkg::ADDR_W-1:0] awAddr_ff;
  logic                       wHeld_ff;
  logic [31:0]                wData_ff;
  logic [3:0]                 wStrb_ff;

  assign awready = ~awHeld_ff;
  assign wready  = ~wHeld_ff;
  assign arready = ~rvalid;

  wire doWrite  = awHeld_ff & wHeld_ff & ~bvalid;
  wire lane0    = wStrb_ff[0];
  wire hitTxctl = awAddr_ff == sio_pkg::ADDR_TXCTL;
  wire hitStat  = awAddr_ff == sio_pkg::ADDR_STAT0;
  wire hitCtrl  = awAddr_ff == sio_pkg::ADDR_CTRL;
  wire hitCmd   = awAddr_ff == sio_pkg::ADDR_CMD;
  wire hitTxbuf = awAddr_ff == sio_pkg::ADDR_TXBUF;
  wire wrMapped = hitTxctl | hitStat | hitCtrl | hitCmd | hitTxbuf;
  wire wrTxctl  = doWrite & hitTxctl & lane0;
  wire wrCtrl   = doWrite & hitCtrl;
  wire wrTxbuf  = doWrite & hitTxbuf & lane0;
  wire wrCmd    = doWrite & hitCmd & lane0;
  wire cmdAbort = wrCmd & (wData_ff[7:0] == sio_pkg::CMD_SEND_ABORT);
  wire cmdExt   = wrCmd & (wData_ff[7:0] == sio_pkg::CMD_RESET_EXT);
  wire cmdEom   = wrCmd & (wData_ff[7:0] == sio_pkg::CMD_RESET_EOM);
  wire cmdHunt  = wrCmd & (wData_ff[7:0] == sio_pkg::CMD_ENTER_HUNT);

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wHeld_ff  <= 1'b0;
      wData_ff  <= 32'h0000_0000;
      wStrb_ff  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= sio_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end else if (doWrite) begin
        awHeld_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end else if (doWrite) begin
        wHeld_ff <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= wrMapped ? sio_pkg::RESP_OKAY : sio_pkg::RESP_DECERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Control registers; status offset takes no write
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      txctl_ff <= sio_pkg::TXCTL_RST;
      ctrl_ff  <= sio_pkg::CTRL_RST;
    end else begin
      if (wrTxctl) txctl_ff <= sio_pkg::txctl_type'(wData_ff[7:0]);
      if (wrCtrl && lane0) ctrl_ff[5:0] <= wData_ff[5:0];
      if (wrCtrl && wStrb_ff[1]) ctrl_ff.syncChar <= wData_ff[15:8];
    end
  end

  wire isAsync  = ctrl_ff.mode == sio_pkg::MODE_ASYNC;
  wire isFramed = ctrl_ff.mode == sio_pkg::MODE_FRAMED;
  wire isExtSyn = ctrl_ff.mode == sio_pkg::MODE_EXTSYNC;
  wire ctsLive  = ~ctsS_n;

  // Transmit gating
  wire txGo = txctl_ff.txEn & ~txctl_ff.sendBreak
            & (~txctl_ff.autoEn | ctsLive);

  // Data bit count from the length field and the marker
  function automatic logic [3:0] dataBits(input logic [1:0] len, input logic [7:0] d);
    logic [3:0] n;
    n = 4'h1;
    unique case (len)
      2'b01: n = 4'h6;
      2'b10: n = 4'h7;
      2'b11: n = 4'h8;
      2'b00: begin
        if (!d[7]) n = 4'h5;
        else if (!d[6]) n = 4'h4;
        else if (!d[5]) n = 4'h3;
        else if (!d[4]) n = 4'h2;
        else n = 4'h1;
      end
    endcase
    return n;
  endfunction

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d,
                                          input logic [3:0] n);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < n) begin
        fb = r[0] ^ d[i];
        r  = r >> 1;
        if (fb) r = r ^ sio_pkg::CRC_POLY;
      end
    end
    return r;
  endfunction

  wire [3:0]  nData    = dataBits(txctl_ff.charLen, bufData_ff);
  wire [7:0]  dataMask = 8'(9'h0ff >> (4'h8 - nData));
  wire [7:0]  dataOnly = bufData_ff & dataMask;
  wire        parBit   = (^dataOnly) ^ ctrl_ff.parityOdd;
  wire [15:0] payload  = {8'h00, dataOnly}
                       | (ctrl_ff.parityEn ? (16'(parBit) << nData) : 16'h0000);
  wire [4:0]  payLen   = 5'(nData) + 5'(ctrl_ff.parityEn);
  wire [15:0] asyncVec = {payload[14:0], 1'b0} | (16'h0002 << payLen);
  wire [15:0] charVec  = isAsync ? asyncVec : payload;
  wire [4:0]  charLen  = isAsync ? (payLen + 5'h02) : payLen;

  wire itemDone  = bitsLeft_ff <= 5'h01;
  wire crcCut    = (txState_ff == sio_pkg::TX_CRC) & ~txctl_ff.txEn;
  wire pickNext  = bitTick & (itemDone | crcCut);
  wire loadChar  = pickNext & ~crcCut & txGo & bufFull_ff;
  wire underrun  = pickNext & ~loadChar & ~isAsync
                 & (txState_ff == sio_pkg::TX_CHAR) & ~bufFull_ff;
  wire appendCrc = underrun & txctl_ff.crcEn & ~eom_ff & txctl_ff.txEn;
  wire syncFill  = pickNext & ~loadChar & ~appendCrc & ~isAsync
                 & (txctl_ff.txEn | crcCut) & ~txctl_ff.sendBreak;

  always_comb begin
    nxt_txState  = txState_ff;
    nxt_shift    = shift_ff;
    nxt_bitsLeft = bitsLeft_ff;
    nxt_crc      = crc_ff;
    if (eom_ff) begin
      nxt_crc = sio_pkg::CRC_PRESET;
    end
    if (loadChar) begin
      nxt_txState  = sio_pkg::TX_CHAR;
      nxt_shift    = charVec;
      nxt_bitsLeft = charLen;
      if (!isAsync && txctl_ff.crcEn) begin
        nxt_crc = crcStep(crc_ff, dataOnly, nData);
      end
    end else if (appendCrc) begin
      nxt_txState  = sio_pkg::TX_CRC;
      nxt_shift    = crc_ff;
      nxt_bitsLeft = sio_pkg::CRC_BITS;
    end else if (syncFill) begin
      nxt_txState  = sio_pkg::TX_SYNC;
      nxt_shift    = {8'h00, ctrl_ff.syncChar};
      nxt_bitsLeft = sio_pkg::SYNC_BITS;
    end else if (pickNext) begin
      nxt_txState  = sio_pkg::TX_IDLE;
      nxt_shift    = 16'hffff;
      nxt_bitsLeft = 5'h00;
    end else if (bitTick && !itemDone) begin
      nxt_shift    = {1'b1, shift_ff[15:1]};
      nxt_bitsLeft = bitsLeft_ff - 5'h01;
    end
  end

  // Underrun latch: disable, send-abort and underrun set, command clears
  wire eomSet = ~txctl_ff.txEn | cmdAbort | underrun;
  assign nxt_eom = eomSet | (eom_ff & ~cmdEom);
  wire eomRise = nxt_eom & ~eom_ff & ~isAsync;

  wire allSent = ~bufFull_ff & (txState_ff == sio_pkg::TX_IDLE);
  wire txEmpty = ~bufFull_ff & (txState_ff != sio_pkg::TX_CRC);

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      txClkPrev_ff <= 1'b1;
      txState_ff   <= sio_pkg::TX_IDLE;
      shift_ff     <= 16'hffff;
      bitsLeft_ff  <= 5'h00;
      crc_ff       <= sio_pkg::CRC_PRESET;
      eom_ff       <= 1'b1;
      bufData_ff   <= 8'h00;
      bufFull_ff   <= 1'b0;
      txData       <= 1'b1;
      dtrPin_n     <= 1'b1;
      rtsOut_ff    <= 1'b1;
    end else begin
      txClkPrev_ff <= txClkS;
      txState_ff   <= nxt_txState;
      shift_ff     <= nxt_shift;
      bitsLeft_ff  <= nxt_bitsLeft;
      crc_ff       <= nxt_crc;
      eom_ff       <= nxt_eom;
      if (wrTxbuf) bufData_ff <= wData_ff[7:0];
      // New write beats a load in the same cycle
      bufFull_ff   <= wrTxbuf | (bufFull_ff & ~loadChar);
      // Break acts at once, enabled or not
      txData       <= txctl_ff.sendBreak ? 1'b0 : nxt_shift[0];
      dtrPin_n     <= ~txctl_ff.dtr;
      if (txctl_ff.rts) rtsOut_ff <= 1'b0;
      else if (!isAsync || allSent) rtsOut_ff <= 1'b1;
    end
  end

  assign rtsPin_n = rtsOut_ff;

  // External/status sources
  wire brkSet  = (isAsync & rxNullFrameErr) | (isFramed & rxAbortSeen);
  wire huntSet = ~isAsync & ~isExtSyn
               & (cmdHunt | ~rxEnable | (isFramed & rxAbortSeen));
  wire huntBit = (isAsync | isExtSyn) ? ~syncS_n : huntLive_ff;
  wire [3:0] liveBits = {brkLive_ff, ctsLive, huntBit, ~dcdS_n};

  // Snapshot freezes until command 2, so later edges wait for it
  wire srcChange = ~locked_ff & (liveBits != snap_ff);
  wire extEvent  = srcChange | eomRise;

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      brkLive_ff  <= 1'b0;
      huntLive_ff <= 1'b1;
      snap_ff     <= 4'h0;
      locked_ff   <= 1'b0;
      pending_ff  <= 1'b0;
    end else begin
      brkLive_ff  <= brkSet | (brkLive_ff & ~rxBreakEnd);
      huntLive_ff <= huntSet | (huntLive_ff & ~rxSyncAchieved);
      if (!locked_ff) snap_ff <= liveBits;
      locked_ff   <= extEvent | (locked_ff & ~cmdExt);
      pending_ff  <= extEvent | (pending_ff & ~cmdExt);
    end
  end

  assign extStatusReq = pending_ff & ctrl_ff.extIntEn;

  sio_pkg::stat0_type stat0;
  always_comb begin
    stat0.brk     = snap_ff[3];
    stat0.end_of_message_latch     = eom_ff;
    stat0.cts     = snap_ff[2];
    stat0.hunt    = snap_ff[1];
    stat0.dcd     = snap_ff[0];
    stat0.txEmpty = txEmpty;
    stat0.pending = pending_ff;
    stat0.rxAvail = rxCharAvail;
  end

  // AXI read side
  wire rdTxctl  = araddr == sio_pkg::ADDR_TXCTL;
  wire rdStat   = araddr == sio_pkg::ADDR_STAT0;
  wire rdCtrl   = araddr == sio_pkg::ADDR_CTRL;
  wire rdWrOnly = (araddr == sio_pkg::ADDR_CMD) | (araddr == sio_pkg::ADDR_TXBUF);
  wire rdHit    = rdTxctl | rdStat | rdCtrl | rdWrOnly;
  wire [31:0] rdMux = rdTxctl ? {24'h000000, txctl_ff}
                    : rdStat ? {24'h000000, stat0}
                    : rdCtrl ? {18'h00000, ctrl_ff}
                    : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= sio_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rdMux;
      rresp  <= rdHit ? sio_pkg::RESP_OKAY : sio_pkg::RESP_DECERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // serial_tx_control_ext_status

// ===== hdl/sync_two_ff.sv
`timescale 1ns/100ps
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= '1;
      syncOut   <= '1;
    end else begin
      stage1_ff <= asyncIn;
      syncOut   <= stage1_ff;
    end
  end

endmodule // sync_two_ff

// ===== shared/sio_pkg.sv
package sio_pkg;

  localparam int ADDR_W = 8;

  // Byte addresses of the word registers
  localparam logic [7:0] ADDR_TXCTL = 8'h00;
  localparam logic [7:0] ADDR_STAT0 = 8'h04;
  localparam logic [7:0] ADDR_CTRL  = 8'h08;
  localparam logic [7:0] ADDR_CMD   = 8'h0c;
  localparam logic [7:0] ADDR_TXBUF = 8'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam logic [7:0] CMD_SEND_ABORT = 8'h01;
  localparam logic [7:0] CMD_RESET_EXT  = 8'h02;
  localparam logic [7:0] CMD_RESET_EOM  = 8'h03;
  localparam logic [7:0] CMD_ENTER_HUNT = 8'h04;

  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY   = 16'h8408;
  localparam logic [4:0]  CRC_BITS   = 5'h10;
  localparam logic [4:0]  SYNC_BITS  = 5'h08;

  typedef enum logic [2:0] {
    MODE_ASYNC    = 3'b000,
    MODE_MONOSYNC = 3'b001,
    MODE_BISYNC   = 3'b010,
    MODE_FRAMED   = 3'b011,
    MODE_EXTSYNC  = 3'b100
  } mode_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_CHAR = 2'b01,
    TX_CRC  = 2'b10,
    TX_SYNC = 2'b11
  } txstate_type;

  typedef struct packed {
    logic [1:0] charLen;
    logic       autoEn;
    logic       sendBreak;
    logic       crcEn;
    logic       dtr;
    logic       rts;
    logic       txEn;
  } txctl_type;

  typedef struct packed {
    logic [7:0] syncChar;
    logic       extIntEn;
    logic       parityOdd;
    logic       parityEn;
    mode_type   mode;
  } ctrl_type;

  typedef struct packed {
    logic brk;
    logic end_of_message_latch;
    logic cts;
    logic hunt;
    logic dcd;
    logic txEmpty;
    logic pending;
    logic rxAvail;
  } stat0_type;

  localparam txctl_type TXCTL_RST = 8'h00;
  localparam ctrl_type  CTRL_RST  = 14'h0000;

endpackage

// ===== testbench/line_model.sv
`timescale 1ns/100ps
module line_model (
  // Bench controls
  input wire logic run,
  input wire logic ctsOn,
  input wire logic dcdOn,
  input wire logic syncOn,
  // Line and modem pins
  input wire logic txData,
  output logic     txClkPin,
  output logic     ctsPin_n,
  output logic     dcdPin_n,
  output logic     syncPin_n
);
  logic bits[$];

  assign ctsPin_n  = ~ctsOn;
  assign dcdPin_n  = ~dcdOn;
  assign syncPin_n = ~syncOn;

  // Bit clock stands high between frames
  initial begin
    txClkPin = 1'b1;
    forever begin
      #80;
      txClkPin = run ? ~txClkPin : 1'b1;
    end
  end

  // A bit launched after one fall is settled at the next
  always @(negedge txClkPin) bits.push_back(txData);
endmodule // line_model

// ===== testbench/serial_tx_control_ext_status_chk.sv
`timescale 1ns/100ps
module serial_tx_control_ext_status_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Register writes
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  // Pins and request
  input wire logic        ctsPin_n,
  input wire logic        dcdPin_n,
  input wire logic        syncPin_n,
  input wire logic        txData,
  input wire logic        rtsPin_n,
  input wire logic        dtrPin_n,
  input wire logic        extStatusReq
);
  logic [7:0] addr_ff;
  logic [7:0] data_ff;
  logic [7:0] txSh_ff;
  logic [5:0] ctrlSh_ff;
  logic       bvalid_ff;
  logic       commit;
  logic       wrTx;

  // Shadow of committed settings, one cycle behind the design
  assign commit = bvalid & ~bvalid_ff & (bresp == sio_pkg::RESP_OKAY);
  assign wrTx   = commit & (addr_ff == sio_pkg::ADDR_TXCTL);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {addr_ff, data_ff, txSh_ff, ctrlSh_ff, bvalid_ff} <= '0;
    end else begin
      bvalid_ff <= bvalid;
      if (awvalid & awready) addr_ff <= awaddr;
      if (wvalid & wready) data_ff <= wdata[7:0];
      if (wrTx) txSh_ff <= data_ff;
      if (commit & (addr_ff == sio_pkg::ADDR_CTRL)) ctrlSh_ff <= data_ff[5:0];
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_BRK_NOW: assert property (wrTx && data_ff[4] |-> ##[0:2] !txData)
    else $error("break write left the line high");
  AST_BRK_HOLD: assert property (txSh_ff[4] [*3] |-> !txData)
    else $error("line not low during break");
  AST_DTR_PIN: assert property (wrTx |-> ##[0:2] dtrPin_n == !data_ff[2])
    else $error("terminal-ready pin not inverse of bit");
  AST_RTS_SET: assert property (txSh_ff[1] [*3] |-> !rtsPin_n)
    else $error("send-request pin high while bit set");
  AST_RTS_SYNC: assert property ((ctrlSh_ff[2:0] != 3'h0 && !txSh_ff[1]) [*3] |-> rtsPin_n)
    else $error("send-request pin low in sync mode with bit clear");
  AST_CTS_REQ: assert property ($changed(ctsPin_n) && ctrlSh_ff[5] |-> ##[1:6] extStatusReq)
    else $error("clear-to-send change raised no request");
  AST_DCD_REQ: assert property ($changed(dcdPin_n) && ctrlSh_ff[5] |-> ##[1:6] extStatusReq)
    else $error("carrier change raised no request");
  AST_SYNC_REQ: assert property ($changed(syncPin_n) && ctrlSh_ff == 6'h20 |-> ##[1:6] extStatusReq)
    else $error("sync pin change raised no request");
  AST_STAT_WR: assert property (commit && addr_ff == sio_pkg::ADDR_STAT0 |-> $stable(extStatusReq))
    else $error("status write moved the request");

  COV_BREAK: cover property (txSh_ff[4] && !txData);
  COV_REQ: cover property ($rose(extStatusReq));
  COV_STAT_WR: cover property (commit && addr_ff == sio_pkg::ADDR_STAT0);
endmodule // serial_tx_control_ext_status_chk

// ===== testbench/serial_tx_control_ext_status_test.sv
`timescale 1ns/100ps
module serial_tx_control_ext_status_test;
  logic        ref_clk;
  logic        rst_n;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  rsp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, run, ctsOn, dcdOn, syncOn;
  logic        txClkPin, ctsPin_n, dcdPin_n, syncPin_n, txData, rtsPin_n, dtrPin_n;
  logic        rxNullFrameErr, rxAbortSeen, rxBreakEnd, rxSyncAchieved, rxEnable;
  logic        rxCharAvail, extStatusReq;
  int          n_mismatch;
  int          total_checks;

  serial_tx_control_ext_status i_serial_tx_control_ext_status (
    .ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .txClkPin(txClkPin),
    .ctsPin_n(ctsPin_n), .dcdPin_n(dcdPin_n), .syncPin_n(syncPin_n), .txData(txData),
    .rtsPin_n(rtsPin_n), .dtrPin_n(dtrPin_n), .rxNullFrameErr(rxNullFrameErr),
    .rxAbortSeen(rxAbortSeen), .rxBreakEnd(rxBreakEnd), .rxSyncAchieved(rxSyncAchieved),
    .rxEnable(rxEnable), .rxCharAvail(rxCharAvail), .extStatusReq(extStatusReq));

  line_model i_line_model (.run(run), .ctsOn(ctsOn), .dcdOn(dcdOn), .syncOn(syncOn),
    .txData(txData), .txClkPin(txClkPin), .ctsPin_n(ctsPin_n), .dcdPin_n(dcdPin_n),
    .syncPin_n(syncPin_n));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic stuck;
    n_mismatch++;
    tally_and_finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Ready sampled mid-cycle is the value seen at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'b0;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (int i = 0; i < 40 && !b; i++) begin
      @(negedge ref_clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      rsp = bresp;
      @(posedge ref_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!b) stuck;
    @(posedge ref_clk);
  endtask

  task automatic rdt(input logic [7:0] a);
    logic ar, v;
    v = 1'b0;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (int i = 0; i < 40 && !v; i++) begin
      @(negedge ref_clk);
      ar = arvalid & arready;
      v = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge ref_clk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!v) stuck;
    @(posedge ref_clk);
  endtask

  task automatic txc(input logic [7:0] v);
    wr(sio_pkg::ADDR_TXCTL, {24'h0, v});
  endtask

  task automatic cmd(input logic [7:0] c);
    wr(sio_pkg::ADDR_CMD, {24'h0, c});
  endtask

  task automatic st;
    rdt(sio_pkg::ADDR_STAT0);
  endtask

  // Runs the bit clock for one frame and cuts out the bits from the start bit
  task automatic frame(input int tot, output logic f, output logic [11:0] w);
    int s;
    s = -1;
    i_line_model.bits.delete();
    run <= 1'b1;
    cyc(120);
    run <= 1'b0;
    w = '0;
    for (int k = 0; k < i_line_model.bits.size(); k++)
      if (s < 0 && i_line_model.bits[k] === 1'b0) s = k;
    f = s >= 0 && s + tot <= i_line_model.bits.size();
    for (int k = 0; f && k < tot; k++) w[k] = i_line_model.bits[s + k];
  endtask

  task automatic t_reset;
    chk({txData, rtsPin_n, dtrPin_n}, 3'h7);
    rdt(sio_pkg::ADDR_TXCTL);
    chk(rd, 32'h0);
    st;
    chk(rd, 32'h44);
    rdt(8'h14);
    chk(rsp, sio_pkg::RESP_DECERR);
    wr(sio_pkg::ADDR_STAT0, 32'hff);
    st;
    chk(rd, 32'h44);
  endtask

  task automatic t_modem;
    logic [7:0] v[4] = '{8'h04, 8'h02, 8'h06, 8'h00};
    for (int k = 0; k < 4; k++) begin
      txc(v[k]);
      cyc(4);
      chk({rtsPin_n, dtrPin_n}, {~v[k][1], ~v[k][2]});
    end
  endtask

  task automatic t_break;
    txc(8'h10);
    cyc(2);
    chk(txData, 1'b0);
    txc(8'h00);
    cyc(2);
    chk(txData, 1'b1);
  endtask

  task automatic t_char(input logic [1:0] len, input logic par, input logic [7:0] d);
    int nb, tot;
    logic f;
    logic [11:0] w, e;
    nb = len != 0 ? len + 5 : !d[7] ? 5 : !d[6] ? 4 : !d[5] ? 3 : !d[4] ? 2 : 1;
    e = '0;
    for (int k = 0; k < nb; k++) e[k + 1] = d[k];
    tot = nb + 1;
    if (par) e[tot] = ^e;
    tot = tot + int'(par);
    e[tot] = 1'b1;
    tot = tot + 1;
    wr(sio_pkg::ADDR_CTRL, par ? 32'h28 : 32'h20);
    txc({len, 6'h01});
    wr(sio_pkg::ADDR_TXBUF, {24'h0, d});
    frame(tot, f, w);
    chk({f, w}, {1'b1, e});
  endtask

  task automatic t_auto;
    logic f;
    logic [11:0] w;
    wr(sio_pkg::ADDR_CTRL, 32'h20);
    txc(8'he1);
    wr(sio_pkg::ADDR_TXBUF, 32'h0f);
    frame(10, f, w);
    chk(f, 1'b0);
    ctsOn <= 1'b1;
    cyc(8);
    st;
    chk({rd[5], rd[1], extStatusReq}, 3'h7);
    frame(10, f, w);
    chk({f, w}, 13'h121e);
    cmd(sio_pkg::CMD_RESET_EXT);
  endtask

  task automatic t_status;
    dcdOn <= 1'b1;
    cyc(8);
    st;
    chk({rd[3], rd[1], extStatusReq}, 3'h7);
    wr(sio_pkg::ADDR_STAT0, 32'h0);
    chk(extStatusReq, 1'b1);
    cmd(sio_pkg::CMD_RESET_EXT);
    st;
    chk({rd[5], rd[3], rd[1]}, 3'h6);
    syncOn <= 1'b1;
    cyc(8);
    st;
    chk({rd[4], rd[1]}, 2'h3);
    cmd(sio_pkg::CMD_RESET_EXT);
    rxNullFrameErr <= 1'b1;
    @(posedge ref_clk);
    rxNullFrameErr <= 1'b0;
    cyc(2);
    st;
    chk({rd[7], rd[1]}, 2'h3);
    cmd(sio_pkg::CMD_RESET_EXT);
    rxBreakEnd <= 1'b1;
    @(posedge ref_clk);
    rxBreakEnd <= 1'b0;
    cyc(2);
    st;
    chk({rd[7], rd[1]}, 2'h1);
    cmd(sio_pkg::CMD_RESET_EXT);
    rxCharAvail <= 1'b1;
    cyc(2);
    st;
    chk(rd[0], 1'b1);
  endtask

  task automatic t_eom;
    cmd(sio_pkg::CMD_RESET_EOM);
    st;
    chk(rd[6], 1'b0);
    cmd(sio_pkg::CMD_SEND_ABORT);
    st;
    chk(rd[6], 1'b1);
    cmd(sio_pkg::CMD_RESET_EOM);
    txc(8'h00);
    st;
    chk({rd[6], rd[1]}, 2'h2);
  endtask

  task automatic t_sync;
    logic f;
    logic [11:0] w;
    wr(sio_pkg::ADDR_CTRL, 32'h3c21);
    rxSyncAchieved <= 1'b1;
    @(posedge ref_clk);
    rxSyncAchieved <= 1'b0;
    cyc(2);
    st;
    chk({rd[4], rd[1]}, 2'h1);
    cmd(sio_pkg::CMD_RESET_EXT);
    cmd(sio_pkg::CMD_ENTER_HUNT);
    st;
    chk({rd[4], rd[1]}, 2'h3);
    txc(8'h02);
    cyc(3);
    chk(rtsPin_n, 1'b0);
    txc(8'h00);
    cyc(2);
    chk(rtsPin_n, 1'b1);
    // Enabled with an empty buffer: sync fill only
    txc(8'h01);
    frame(8, f, w);
    chk({f, w}, 13'h103c);
    cyc(5);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    stuck;
  end

  initial begin
    {rst_n, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {run, ctsOn, dcdOn, syncOn, rxNullFrameErr, rxAbortSeen, rxBreakEnd} = '0;
    {rxSyncAchieved, rxCharAvail} = '0;
    rxEnable = 1'b1;
    wstrb = 4'hf;
    n_mismatch = 0;
    total_checks = 0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(4);
    t_reset;
    t_modem;
    t_break;
    t_char(2'h3, 1'b0, 8'h55);
    t_char(2'h2, 1'b0, 8'hd3);
    t_char(2'h1, 1'b0, 8'h2c);
    t_char(2'h0, 1'b0, 8'he5);
    t_char(2'h0, 1'b0, 8'h13);
    t_char(2'h3, 1'b1, 8'h07);
    t_auto;
    t_status;
    t_eom;
    t_sync;
    tally_and_finish;
  end
endmodule // serial_tx_control_ext_status_test

bind serial_tx_control_ext_status serial_tx_control_ext_status_chk
  i_serial_tx_control_ext_status_chk (.ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .ctsPin_n(ctsPin_n), .dcdPin_n(dcdPin_n),
  .syncPin_n(syncPin_n), .txData(txData), .rtsPin_n(rtsPin_n), .dtrPin_n(dtrPin_n),
  .extStatusReq(extStatusReq));
